//--- common/fvsu_defs.svh
// fvsu_defs.svh: constants for the fractional vector subtract unit.
// assumes the standard 32-bit instruction layout of the core decode stage.
`ifndef FVSU_DEFS_SVH
`define FVSU_DEFS_SVH

// instruction field positions
`define FVSU_MAJOR_HI      31
`define FVSU_MAJOR_LO      26
`define FVSU_SUBOP_HI      10
`define FVSU_SUBOP_LO      6
`define FVSU_FUNC_HI       5
`define FVSU_FUNC_LO       0

// major opcode group
`define FVSU_MAJOR_GROUP   6'h1f

// function codes
`define FVSU_FUNC_OCTAL    6'h14
`define FVSU_FUNC_QUAD     6'h10
`define FVSU_FUNC_HALVING  6'h18

// sub-operation codes
`define FVSU_SUB_PW_WRAP   5'h13
`define FVSU_SUB_PW_SAT    5'h17
`define FVSU_SUB_QH_WRAP   5'h0b
`define FVSU_SUB_QH_SAT    5'h0f
`define FVSU_SUB_SW_SAT    5'h17
`define FVSU_SUB_HPH_TRUNC 5'h09
`define FVSU_SUB_HPH_ROUND 5'h0b

// overflow flag position in the extension control register
`define FVSU_OUFLAG_BIT    20

// lane widths and datapath width
`define FVSU_WORD_W        32
`define FVSU_HALF_W        16
`define FVSU_DATA_W        64

// reset values
`define FVSU_RESULT_RST    64'h0000000000000000

`endif

//--- common/fvsu_pkg.sv
// fvsu_pkg: types shared by the fractional vector subtract unit.
// assumes fvsu_defs.svh is on the include path.
`default_nettype none

package fvsu_pkg;

	typedef enum logic [3:0] {
		FVSU_OP_NONE       = 4'h0,
		FVSU_OP_PW_WRAP    = 4'h1,
		FVSU_OP_PW_SAT     = 4'h2,
		FVSU_OP_QH_WRAP    = 4'h3,
		FVSU_OP_QH_SAT     = 4'h4,
		FVSU_OP_SW_SAT     = 4'h5,
		FVSU_OP_HPH_TRUNC  = 4'h6,
		FVSU_OP_HPH_ROUND  = 4'h7
	} fvsu_op_e;

	typedef logic [63:0] fvsu_data_t;

endpackage : fvsu_pkg

`default_nettype wire

//--- rtl/fvsu_lane.sv
// fvsu_lane: one signed fractional subtract lane, wrapping or saturating.
// purely combinational; the caller registers the outputs.
`default_nettype none

module fvsu_lane #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] a_in,
	input  wire logic [W-1:0] b_in,
	input  wire logic         sat_in,
	output logic      [W-1:0] res_out,
	output logic              ovf_out,
	output logic      [W:0]   diff_out
);

	wire logic [W:0]   diff;
	wire logic         ovf;
	wire logic [W-1:0] clamp;

	assign diff = {a_in[W-1], a_in} - {b_in[W-1], b_in};
	// top two bits disagree on overflow
	assign ovf = diff[W] ^ diff[W-1];
	assign clamp = diff[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
	assign res_out  = (sat_in && ovf) ? clamp : diff[W-1:0];
	assign ovf_out  = ovf;
	assign diff_out = diff;

endmodule : fvsu_lane

`default_nettype wire

//--- rtl/fvsu_unit.sv
// fvsu_unit: fractional vector subtract execution unit, one-cycle latency.
// assumes the core supplies the instruction and both source registers in the
// same cycle as op_valid_in, and merges ouflag_set_out into its control reg.
`default_nettype none
`include "fvsu_defs.svh"

module fvsu_unit (
	input  wire logic               clk_in,
	input  wire logic               reset_in,
	input  wire logic               op_valid_in,
	input  wire logic [31:0]        instr_in,
	input  wire logic               ext_enable_in,
	input  wire fvsu_pkg::fvsu_data_t operand_one_reg_in,
	input  wire fvsu_pkg::fvsu_data_t operand_two_reg_in,
	output fvsu_pkg::fvsu_data_t    result_out,
	output logic                    result_valid_out,
	output logic                    ouflag_set_out,
	output logic                    exc_disabled_out,
	output logic                    exc_reserved_out
);

	import fvsu_pkg::*;

	localparam int HW = `FVSU_HALF_W;
	localparam int WW = `FVSU_WORD_W;
	localparam int NH = `FVSU_DATA_W / `FVSU_HALF_W;
	localparam int NW = `FVSU_DATA_W / `FVSU_WORD_W;

	fvsu_data_t result_ff;
	logic       result_valid_ff;
	logic       ouflag_set_ff;
	logic       exc_disabled_ff;
	logic       exc_reserved_ff;

	wire logic [5:0] major;
	wire logic [5:0] func;
	wire logic [4:0] subop;
	wire logic       in_group;
	wire logic       is_octal;
	wire logic       is_quad;
	wire logic       is_halving;
	fvsu_op_e        op;
	wire logic       op_known;
	wire logic       sat_sel;
	wire logic       go;

	// field extraction
	assign major = instr_in[`FVSU_MAJOR_HI:`FVSU_MAJOR_LO];
	assign func  = instr_in[`FVSU_FUNC_HI:`FVSU_FUNC_LO];
	assign subop = instr_in[`FVSU_SUBOP_HI:`FVSU_SUBOP_LO];

	assign in_group   = (major == `FVSU_MAJOR_GROUP);
	assign is_octal   = in_group && (func == `FVSU_FUNC_OCTAL);
	assign is_quad    = in_group && (func == `FVSU_FUNC_QUAD);
	assign is_halving = in_group && (func == `FVSU_FUNC_HALVING);

	assign op =
		(is_octal   && subop == `FVSU_SUB_PW_WRAP)   ? FVSU_OP_PW_WRAP   :
		(is_octal   && subop == `FVSU_SUB_PW_SAT)    ? FVSU_OP_PW_SAT    :
		(is_octal   && subop == `FVSU_SUB_QH_WRAP)   ? FVSU_OP_QH_WRAP   :
		(is_octal   && subop == `FVSU_SUB_QH_SAT)    ? FVSU_OP_QH_SAT    :
		(is_quad    && subop == `FVSU_SUB_SW_SAT)    ? FVSU_OP_SW_SAT    :
		(is_halving && subop == `FVSU_SUB_HPH_TRUNC) ? FVSU_OP_HPH_TRUNC :
		(is_halving && subop == `FVSU_SUB_HPH_ROUND) ? FVSU_OP_HPH_ROUND :
		FVSU_OP_NONE;

	assign op_known = (op != FVSU_OP_NONE);
	// a refused op leaves result_ff alone; the core may still read the last
	// executed value, so it must never be disturbed by an op that was not run
	assign go       = op_valid_in && op_known && ext_enable_in;

	// only saturating variants clamp; halving forms never look at sat
	assign sat_sel = (op == FVSU_OP_PW_SAT) || (op == FVSU_OP_QH_SAT) ||
		(op == FVSU_OP_SW_SAT);

	// lane array
	// lanes run every cycle whatever the op; the result mux picks one set,
	// trading some switching power for a short, fixed decode-to-result path
	wire logic [NH*HW-1:0]     half_res;
	wire logic [NH-1:0]        half_ovf;
	wire logic [NH*(HW+1)-1:0] half_diff;
	wire logic [NW*WW-1:0]     word_res;
	wire logic [NW-1:0]        word_ovf;

	genvar gi;
	generate
		for (gi = 0; gi < NH; gi++) begin : g_half
			fvsu_lane #(.W(HW)) u_lane (
				.a_in     (operand_one_reg_in[gi*HW +: HW]),
				.b_in     (operand_two_reg_in[gi*HW +: HW]),
				.sat_in   (sat_sel),
				.res_out  (half_res[gi*HW +: HW]),
				.ovf_out  (half_ovf[gi]),
				.diff_out (half_diff[gi*(HW+1) +: HW+1])
			);
		end
		for (gi = 0; gi < NW; gi++) begin : g_word
			fvsu_lane #(.W(WW)) u_lane (
				.a_in     (operand_one_reg_in[gi*WW +: WW]),
				.b_in     (operand_two_reg_in[gi*WW +: WW]),
				.sat_in   (sat_sel),
				.res_out  (word_res[gi*WW +: WW]),
				.ovf_out  (word_ovf[gi]),
				.diff_out ()
			);
		end
	endgenerate

	// halving path
	wire logic        round_sel;
	wire logic [HW:0] interim_lo;
	wire logic [HW:0] interim_hi;
	wire logic [HW:0] adj_lo;
	wire logic [HW:0] adj_hi;
	wire logic [HW-1:0] halve_lo;
	wire logic [HW-1:0] halve_hi;

	assign interim_lo = half_diff[0 +: HW+1];
	assign interim_hi = half_diff[HW+1 +: HW+1];
	assign round_sel  = (op == FVSU_OP_HPH_ROUND);

	assign adj_lo   = interim_lo + {{HW{1'b0}}, round_sel};
	assign adj_hi   = interim_hi + {{HW{1'b0}}, round_sel};
	assign halve_lo = adj_lo[HW:1];
	assign halve_hi = adj_hi[HW:1];

	// result selection
	fvsu_data_t nxt_result;
	logic       nxt_ouflag;

	always_comb begin
		nxt_result = `FVSU_RESULT_RST;
		nxt_ouflag = 1'b0;
		unique case (op)
			FVSU_OP_PW_WRAP, FVSU_OP_PW_SAT: begin
				nxt_result = word_res;
				nxt_ouflag = |word_ovf;
			end
			FVSU_OP_QH_WRAP, FVSU_OP_QH_SAT: begin
				nxt_result = half_res;
				nxt_ouflag = |half_ovf;
			end
			FVSU_OP_SW_SAT: begin
				nxt_result = {{WW{word_res[WW-1]}}, word_res[WW-1:0]};
				nxt_ouflag = word_ovf[0];
			end
			FVSU_OP_HPH_TRUNC, FVSU_OP_HPH_ROUND: begin
				// no flag from halving
				// upper word repeats the high halfword's sign so the whole
				// register reads as one signed value
				nxt_result = {{WW{halve_hi[HW-1]}}, halve_hi, halve_lo};
				nxt_ouflag = 1'b0;
			end
			FVSU_OP_NONE: begin
				nxt_result = `FVSU_RESULT_RST;
				nxt_ouflag = 1'b0;
			end
		endcase
	end

	wire logic nxt_exc_disabled;
	wire logic nxt_exc_reserved;
	assign nxt_exc_disabled = op_valid_in && op_known && !ext_enable_in;
	assign nxt_exc_reserved = op_valid_in && !op_known;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			result_ff       <= `FVSU_RESULT_RST;
			result_valid_ff <= 1'b0;
			ouflag_set_ff   <= 1'b0;
		end else begin
			result_ff       <= go ? nxt_result : result_ff;
			result_valid_ff <= go;
			ouflag_set_ff   <= go && nxt_ouflag;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			exc_disabled_ff <= 1'b0;
			exc_reserved_ff <= 1'b0;
		end else begin
			exc_disabled_ff <= nxt_exc_disabled;
			exc_reserved_ff <= nxt_exc_reserved;
		end
	end

	// the core ors this into bit 20; the unit never clears it, so the flag
	// stays sticky even when a later op reports no overflow
	assign result_out       = result_ff;
	assign result_valid_out = result_valid_ff;
	assign ouflag_set_out   = ouflag_set_ff;
	assign exc_disabled_out = exc_disabled_ff;
	assign exc_reserved_out = exc_reserved_ff;

endmodule : fvsu_unit

`default_nettype wire

//--- tb/fvsu_unit_props.sv
// fvsu_unit_props: port-level checks of the subtract unit.
// assumes a bind onto fvsu_unit; one clock domain.
`default_nettype none
`include "fvsu_defs.svh"
module fvsu_unit_props (
	input wire logic                 clk_in,
	input wire logic                 reset_in,
	input wire logic                 op_valid_in,
	input wire logic [31:0]          instr_in,
	input wire logic                 ext_enable_in,
	input wire fvsu_pkg::fvsu_data_t operand_one_reg_in,
	input wire fvsu_pkg::fvsu_data_t operand_two_reg_in,
	input wire fvsu_pkg::fvsu_data_t result_out,
	input wire logic                 result_valid_out,
	input wire logic                 ouflag_set_out,
	input wire logic                 exc_disabled_out,
	input wire logic                 exc_reserved_out
);
	import fvsu_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire logic grp = instr_in[31:26] == `FVSU_MAJOR_GROUP;
	wire logic halv = grp && instr_in[5:0] == `FVSU_FUNC_HALVING
		&& (instr_in[10:6] == `FVSU_SUB_HPH_TRUNC || instr_in[10:6] == `FVSU_SUB_HPH_ROUND);
	wire logic fquad = grp && instr_in[5:0] == `FVSU_FUNC_QUAD;
	wire logic sw = fquad && instr_in[10:6] == `FVSU_SUB_SW_SAT;
	wire logic pws = grp && instr_in[5:0] == `FVSU_FUNC_OCTAL && instr_in[10:6] == `FVSU_SUB_PW_SAT;
	wire logic [32:0] dlo = {operand_one_reg_in[31], operand_one_reg_in[31:0]}
		- {operand_two_reg_in[31], operand_two_reg_in[31:0]};
	wire logic dneg = dlo[32];
	sequence s_issue;
		op_valid_in && ext_enable_in;
	endsequence
	sequence s_answer;
		result_valid_out || exc_disabled_out || exc_reserved_out;
	endsequence
	AST_ONE_CYCLE: assert property (
		op_valid_in |=> s_answer) else $error("no answer one cycle after issue");
	AST_QUIET: assert property (
		!op_valid_in |=> !(result_valid_out || exc_disabled_out || exc_reserved_out))
		else $error("answer without issue");
	AST_HOLD: assert property (
		!result_valid_out |-> $stable(result_out)) else $error("result moved without valid");
	AST_DISABLED: assert property (
		op_valid_in && !ext_enable_in |=> !result_valid_out && !ouflag_set_out)
		else $error("result while extension disabled");
	AST_HALVE_FLAG: assert property (
		s_issue and halv |=> result_valid_out && !ouflag_set_out) else $error("halving set flag");
	AST_WORD_SEXT: assert property (
		s_issue and sw |=> result_valid_out && result_out[63:32] == {32{result_out[31]}})
		else $error("single word not sign extended");
	AST_FLAG_PAIR: assert property (
		ouflag_set_out |-> result_valid_out) else $error("flag without result");
	AST_EXCL: assert property (
		$onehot0({result_valid_out, exc_disabled_out, exc_reserved_out})) else $error("two answers");
	AST_PW_CLAMP: assert property (
		s_issue and pws && dlo[32] != dlo[31] |=> ouflag_set_out
		&& result_out[31:0] == ($past(dneg) ? 32'h80000000 : 32'h7fffffff)) else $error("bad clamp");
endmodule : fvsu_unit_props
`default_nettype wire

//--- tb/fvsu_ctl_model.sv
// fvsu_ctl_model: core side holding the sticky overflow bit.
// assumes set pulses come with the unit's result pulse.
`default_nettype none
module fvsu_ctl_model (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic set_in,
	output logic      flag_out
);
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) flag_out <= 1'b0;
		else if (set_in) flag_out <= 1'b1;
	end
endmodule : fvsu_ctl_model
`default_nettype wire

//--- tb/test_fvsu_unit.sv
// test_fvsu_unit: corner and random subtracts against a lane model.
// assumes fvsu_unit answers one cycle after issue.
`default_nettype none
`include "fvsu_defs.svh"
module test_fvsu_unit;
	timeunit 1ns;
	timeprecision 1ns;
	import fvsu_pkg::*;
	logic clk_in, reset_in = 1, vld = 0, en = 1, rv, of, ed, er, flag;
	logic [31:0] instr = 0;
	fvsu_data_t opa = 0, opb = 0, res;
	int num_errors = 0, tests_run = 0, cyc = 0;
	logic [10:0] code [7] = '{{`FVSU_FUNC_OCTAL, `FVSU_SUB_PW_WRAP},
		{`FVSU_FUNC_OCTAL, `FVSU_SUB_PW_SAT}, {`FVSU_FUNC_OCTAL, `FVSU_SUB_QH_WRAP},
		{`FVSU_FUNC_OCTAL, `FVSU_SUB_QH_SAT}, {`FVSU_FUNC_QUAD, `FVSU_SUB_SW_SAT},
		{`FVSU_FUNC_HALVING, `FVSU_SUB_HPH_TRUNC}, {`FVSU_FUNC_HALVING, `FVSU_SUB_HPH_ROUND}};
	fvsu_unit fvsu_unit_i (.clk_in(clk_in), .reset_in(reset_in), .op_valid_in(vld),
		.instr_in(instr), .ext_enable_in(en), .operand_one_reg_in(opa),
		.operand_two_reg_in(opb), .result_out(res), .result_valid_out(rv),
		.ouflag_set_out(of), .exc_disabled_out(ed), .exc_reserved_out(er));
	fvsu_ctl_model fvsu_ctl_model_i (.clk_in(clk_in), .reset_in(reset_in), .set_in(of),
		.flag_out(flag));
	initial begin
		clk_in = 0;
		forever #10 clk_in = ~clk_in;
	end
	function automatic longint lane(longint a, longint b, int w, bit sat, inout bit f);
		longint mx, d;
		mx = (longint'(1) << (w - 1)) - 1;
		d = a - b;
		if (d > mx || d < -mx - 1) begin
			f = 1;
			if (sat) d = d > mx ? mx : -mx - 1;
		end
		return d;
	endfunction : lane
	function automatic longint hf(fvsu_data_t v, int k);
		return longint'($signed(v[16*k+:16]));
	endfunction : hf
	function automatic longint wd(fvsu_data_t v, int k);
		return longint'($signed(v[32*k+:32]));
	endfunction : wd
	function automatic fvsu_data_t expect_res(int op, fvsu_data_t a, b, inout bit f);
		fvsu_data_t r;
		longint d;
		r = 0;
		case (op)
			0, 1: for (int k = 0; k < 2; k++) r[32*k+:32] = lane(wd(a, k), wd(b, k), 32, op == 1, f);
			2, 3: for (int k = 0; k < 4; k++) r[16*k+:16] = lane(hf(a, k), hf(b, k), 16, op == 3, f);
			4: r = lane(wd(a, 0), wd(b, 0), 32, 1, f);
			default: begin
				for (int k = 0; k < 2; k++) begin
					d = (hf(a, k) - hf(b, k) + longint'(op == 6)) >>> 1;
					r[16*k+:16] = d[15:0];
				end
				r[63:32] = {32{r[31]}};
			end
		endcase
		return r;
	endfunction : expect_res
	task automatic chk64(input fvsu_data_t g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk64
	task automatic chk1(input logic g, e);
		chk64({63'h0, g}, {63'h0, e});
	endtask : chk1
	task automatic run(input int op, input bit on, input bit bad, input fvsu_data_t a, b);
		fvsu_data_t e, last;
		bit f;
		f = 0;
		last = res;
		e = expect_res(op, a, b, f);
		vld <= 1'b1;
		en <= on;
		opa <= a;
		opb <= b;
		instr <= {`FVSU_MAJOR_GROUP, 15'($urandom), code[op][4:0], bad ? 6'h3f : code[op][10:5]};
		@(posedge clk_in);
		vld <= 1'b0;
		// answer pulses stand only in the cycle after the taking edge: look mid-cycle
		@(negedge clk_in);
		if (bad) begin
			chk1(er, 1'b1);
			chk1(rv, 1'b0);
		end else if (!on) begin
			chk1(ed, 1'b1);
			chk1(rv, 1'b0);
			chk64(res, last);
		end else begin
			chk1(rv, 1'b1);
			chk64(res, e);
			chk1(of, f);
		end
		@(posedge clk_in);
	endtask : run
	task automatic tally_and_finish;
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'he7690e25));
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int op = 0; op < 7; op++) begin
			run(op, 1, 0, 64'h80008000_80008000, 64'h00010001_00010001);
			run(op, 1, 0, 64'h7fff7fff_7fff7fff, 64'h80008000_80008000);
			repeat (30) run(op, 1, 0, {$urandom, $urandom}, {$urandom, $urandom});
			run(op, 0, 0, {$urandom, $urandom}, 64'h1);
		end
		run(0, 1, 1, 64'h5, 64'h3);
		chk1(flag, 1'b1);
		// mid-run reset clears the result; first op on the first edge after release
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk64(res, `FVSU_RESULT_RST);
		chk1(rv, 1'b0);
		reset_in <= 1'b0;
		run(1, 1, 0, 64'h80000000_80000000, 64'h00000001_00000001);
		tally_and_finish();
	end
endmodule : test_fvsu_unit
bind fvsu_unit fvsu_unit_props fvsu_unit_props_i (.clk_in(clk_in), .reset_in(reset_in),
	.op_valid_in(op_valid_in), .instr_in(instr_in), .ext_enable_in(ext_enable_in),
	.operand_one_reg_in(operand_one_reg_in), .operand_two_reg_in(operand_two_reg_in),
	.result_out(result_out), .result_valid_out(result_valid_out),
	.ouflag_set_out(ouflag_set_out), .exc_disabled_out(exc_disabled_out),
	.exc_reserved_out(exc_reserved_out));
`default_nettype wire
